// *** core/byte_fifo.sv ***
`timescale 1ns/1ns
module byte_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32,
  parameter int LW = $clog2(DEPTH + 1)
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [LW-1:0] level_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  assign in_ready_o = (level_o != LW'(DEPTH));
  assign out_valid_o = (level_o != '0);
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level_o <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      level_o <= level_o + LW'(push) - LW'(pop);
    end
  end
endmodule

// *** core/pin_sync3.sv ***
`timescale 1ns/1ns
module pin_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // a change is taken once the second and third stages agree
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q_o <= '0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      q_o <= (s2 & s3) | (q_o & (s2 | s3));
    end
  end
endmodule

// *** core/ulpi_lp_pkg.sv ***
package ulpi_lp_pkg;
  // timing
  localparam int CLK_PERIOD_PS = 10000;
  localparam int FS_BIT_PS = 83333;
  localparam int LS_BIT_PS = 666667;
  localparam int FS_BIT_CYCLES = (FS_BIT_PS / CLK_PERIOD_PS < 1) ? 1 : FS_BIT_PS / CLK_PERIOD_PS;
  localparam int LS_BIT_CYCLES = (LS_BIT_PS / CLK_PERIOD_PS < 1) ? 1 : LS_BIT_PS / CLK_PERIOD_PS;
  localparam int HS_BIT_CYCLES = 1;
  localparam int START_NS = 10000;
  localparam int FAST_START_NS = 1000;
  localparam int START_CYCLES_DFLT = (START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FAST_START_CYCLES_DFLT = (FAST_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LP_ENTRY_EDGES = 5;
  localparam int EOP_SE0_BITS = 2;
  localparam int EOP_J_BITS = 1;
  localparam int STUFF_LIMIT = 6;
  localparam int FIFO_DEPTH_DFLT = 32;
  localparam int DATA_W = 8;
  localparam logic [7:0] SYNC_BYTE = 8'h80;
  // command encodings
  localparam logic [1:0] TXCMD_TYPE = 2'h1;
  localparam logic [1:0] TXCMD_SUB = 2'h0;
  localparam logic [1:0] REGW_TYPE = 2'h2;
  localparam logic [3:0] NOPID = 4'h0;
  localparam logic [1:0] OPMODE_NODRIVE = 2'h1;
  localparam logic [1:0] SPEED_HS = 2'h0;
  localparam logic [1:0] SPEED_LS = 2'h2;
  // register map and fields
  localparam logic [5:0] FUNC_CTRL_ADDR = 6'h04;
  localparam logic [5:0] IRQ_RISE_ADDR = 6'h0D;
  localparam logic [5:0] IRQ_FALL_ADDR = 6'h10;
  localparam logic [5:0] SPEED_TUNE_ADDR = 6'h31;
  localparam logic [7:0] FUNC_CTRL_RST = 8'h41;
  localparam logic [3:0] IRQ_EN_RST = 4'hF;
  localparam logic SPEED_TUNE_RST = 1'h0;
  localparam int FC_SPEED_LSB = 0;
  localparam int FC_TERM_BIT = 2;
  localparam int FC_OPMODE_LSB = 3;
  localparam int FC_LPEXIT_BIT = 6;
  localparam int ST_FAST_WAKE_BIT = 0;

  typedef struct packed {
    logic id_grounded;
    logic session_end;
    logic session_valid;
    logic bus_power_valid;
  } cmp_t;

  typedef struct packed {
    logic id;
    logic [1:0] rx_event;
    logic pad;
    logic [1:0] vbus_state;
    logic [1:0] linestate;
  } rxcmd_t;
endpackage

// *** core/ulpi_tx_low_power_ctrl.sv ***
`timescale 1ns/1ns
module ulpi_tx_low_power_ctrl
  import ulpi_lp_pkg::*;
#(
  parameter int START_CYCLES = START_CYCLES_DFLT,
  parameter int FAST_START_CYCLES = FAST_START_CYCLES_DFLT,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DFLT
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // link side interface
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input wire logic stp_i,
  output logic dir_o,
  output logic nxt_o,
  output logic clock_output_pin_en_o,
  // usb lines
  input wire logic dp_rx_i,
  input wire logic dm_rx_i,
  output logic dp_o,
  output logic dm_o,
  output logic line_oe_o,
  // analog blocks
  input wire cmp_t cmp_i,
  output logic [3:0] cmp_en_o,
  output logic fs_rx_en_o,
  output logic low_power_o,
  // transceiver configuration
  output logic [1:0] transceiver_speed_select_o,
  output logic termination_select_o,
  output logic [1:0] opmode_o
);
  localparam int LW = $clog2(FIFO_DEPTH + 1);
  localparam logic [LW-1:0] ROOM_LVL = LW'(FIFO_DEPTH - 2);

  typedef enum logic [3:0] {
    M_IDLE, M_CMD, M_TX, M_DRAIN, M_REG_ADDR, M_REG_DATA, M_REG_STP,
    M_RX_TA, M_RX_CMD, M_RX_END, M_LP_ENTER, M_LP, M_WAKE, M_WAKE_HOLD
  } main_t;
  typedef enum logic [1:0] {X_IDLE, X_DATA, X_SE0, X_J} ser_t;

  main_t state;
  main_t next_state;
  ser_t ser;
  logic [7:0] func_ctrl;
  logic [3:0] rise_en;
  logic [3:0] fall_en;
  logic fast_wake_enable;
  logic [5:0] reg_addr;
  logic [15:0] cnt;
  logic irq;
  cmp_t cmp_last;
  logic [1:0] ls_last;
  logic tx_end;
  logic rx_req;
  logic [6:0] bit_cnt;
  logic [7:0] shreg;
  logic have;
  logic [2:0] bit_idx;
  logic [2:0] ones;
  logic [1:0] eop_cnt;
  logic level;
  logic ser_done;

  // synchronised pins
  logic [6:0] pins_s;
  pin_sync3 #(.W(7)) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i({stp_i, dm_rx_i, dp_rx_i, cmp_i}),
    .q_o(pins_s)
  );
  wire cmp_t cmp_s = cmp_t'(pins_s[3:0]);
  wire dp_s = pins_s[4];
  wire dm_s = pins_s[5];
  wire stp_s = pins_s[6];
  wire [1:0] linestate = {dm_s, dp_s};

  // transmit buffer
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire [LW-1:0] fifo_level;
  wire [3:0] cmd_pid = data_i[3:0];
  wire take_pid = (state == M_CMD) && (cmd_pid != NOPID);
  wire take_byte = (state == M_TX) && nxt_o && !stp_i;
  wire fifo_push = take_pid | take_byte;
  wire [7:0] fifo_in_data = take_pid ? {~cmd_pid, cmd_pid} : data_i;
  wire fifo_pop;

  byte_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data),
    .level_o(fifo_level)
  );

  // command decode
  wire is_txcmd = (data_i[7:6] == TXCMD_TYPE) && (data_i[5:4] == TXCMD_SUB);
  wire is_regw = (data_i[7:6] == REGW_TYPE);
  wire reg_we = (state == M_REG_DATA);
  wire [1:0] speed = func_ctrl[FC_SPEED_LSB +: 2];
  wire [1:0] opmode = func_ctrl[FC_OPMODE_LSB +: 2];
  wire fs_ls = (speed != SPEED_HS);
  wire lp_exit = func_ctrl[FC_LPEXIT_BIT];

  // bit rate enable
  wire [6:0] bit_cycles = (speed == SPEED_HS) ? 7'(HS_BIT_CYCLES) :
                          (speed == SPEED_LS) ? 7'(LS_BIT_CYCLES) : 7'(FS_BIT_CYCLES);
  wire bit_tick = (bit_cnt == 7'h00);

  // serializer byte source and bit stuffing
  wire stuff = (ones == 3'(STUFF_LIMIT));
  wire avail = have | fifo_out_valid;
  wire [7:0] cur_byte = have ? shreg : fifo_out_data;
  wire cur_bit = cur_byte[bit_idx];
  assign fifo_pop = bit_tick && (ser == X_DATA) && !stuff && !have && fifo_out_valid;
  wire ser_start = bit_tick && (ser == X_IDLE) && fifo_out_valid && (state == M_TX || state == M_DRAIN);

  // low power bus byte and interrupt sources
  wire [3:0] rise_hit = cmp_s & ~cmp_last & rise_en;
  wire [3:0] fall_hit = ~cmp_s & cmp_last & fall_en;
  wire [7:0] lp_byte = {4'h0, irq, 1'b0, dm_s, dp_s};
  wire rxcmd_t rxcmd = '{id: cmp_s.id_grounded, rx_event: 2'h0, pad: 1'b0,
                          vbus_state: {cmp_s.bus_power_valid, cmp_s.session_valid}, linestate: linestate};
  wire ls_change = (linestate != ls_last);
  wire [15:0] start_len = fast_wake_enable ? 16'(FAST_START_CYCLES) : 16'(START_CYCLES);

  // main sequencer
  always_comb begin
    next_state = state;
    case (state)
      M_IDLE: begin
        if (rx_req) begin
          next_state = M_RX_TA;
        end else if (is_txcmd) begin
          next_state = M_CMD;
        end else if (is_regw) begin
          next_state = M_REG_ADDR;
        end
      end
      M_CMD: next_state = M_TX;
      M_TX: begin
        if (nxt_o && stp_i) begin
          next_state = M_DRAIN;
        end
      end
      M_DRAIN: begin
        if (rx_req) begin
          next_state = M_RX_TA;
        end else if (!tx_end && ser == X_IDLE && !fifo_out_valid) begin
          next_state = M_IDLE;
        end
      end
      M_REG_ADDR: next_state = M_REG_DATA;
      M_REG_DATA: next_state = M_REG_STP;
      M_REG_STP: begin
        if (stp_i) begin
          next_state = lp_exit ? M_IDLE : M_LP_ENTER;
        end
      end
      M_RX_TA: next_state = M_RX_CMD;
      M_RX_CMD: next_state = M_RX_END;
      M_RX_END: next_state = M_DRAIN;
      M_LP_ENTER: begin
        if (cnt == 16'(LP_ENTRY_EDGES)) begin
          next_state = M_LP;
        end
      end
      M_LP: begin
        if (stp_s) begin
          next_state = M_WAKE;
        end
      end
      M_WAKE: begin
        if (!stp_s) begin
          next_state = M_LP;
        end else if (cnt >= start_len) begin
          next_state = M_WAKE_HOLD;
        end
      end
      M_WAKE_HOLD: begin
        if (!stp_i) begin
          next_state = M_IDLE;
        end
      end
      default: next_state = M_IDLE;
    endcase
  end

  wire next_dir = (next_state == M_RX_TA) || (next_state == M_RX_CMD) ||
                  (next_state == M_LP_ENTER) || (next_state == M_LP) || (next_state == M_WAKE);
  wire next_lp_bus = (next_state == M_LP_ENTER) || (next_state == M_LP) || (next_state == M_WAKE);
  wire next_nxt = (next_state == M_CMD) || (next_state == M_REG_ADDR) || (next_state == M_REG_DATA) ||
                  ((next_state == M_TX) && (fifo_level < ROOM_LVL) && fifo_in_ready);
  wire next_clk_en = !((next_state == M_LP) || (next_state == M_WAKE));
  wire lp_now = (state == M_LP) || (state == M_WAKE);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= M_IDLE;
      dir_o <= 1'b0;
      data_oe_o <= 1'b0;
      data_o <= 8'h00;
      nxt_o <= 1'b0;
      clock_output_pin_en_o <= 1'b1;
      low_power_o <= 1'b0;
    end else begin
      state <= next_state;
      dir_o <= next_dir;
      data_oe_o <= next_dir & dir_o;
      // clock keeps running inside, so the low power byte tracks pins within a few cycles
      data_o <= next_lp_bus ? lp_byte : rxcmd;
      nxt_o <= next_nxt;
      clock_output_pin_en_o <= next_clk_en;
      low_power_o <= !next_clk_en;
    end
  end

  // configuration registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      func_ctrl <= FUNC_CTRL_RST;
      rise_en <= IRQ_EN_RST;
      fall_en <= IRQ_EN_RST;
      fast_wake_enable <= SPEED_TUNE_RST;
      reg_addr <= 6'h00;
    end else begin
      if (state == M_IDLE && is_regw) begin
        reg_addr <= data_i[5:0];
      end
      if (state == M_WAKE && next_state == M_WAKE_HOLD) begin
        func_ctrl[FC_LPEXIT_BIT] <= 1'b1;
      end else if (reg_we && reg_addr == FUNC_CTRL_ADDR) begin
        func_ctrl <= data_i;
      end
      if (reg_we && reg_addr == IRQ_RISE_ADDR) begin
        rise_en <= data_i[3:0];
      end
      if (reg_we && reg_addr == IRQ_FALL_ADDR) begin
        fall_en <= data_i[3:0];
      end
      if (reg_we && reg_addr == SPEED_TUNE_ADDR) begin
        fast_wake_enable <= data_i[ST_FAST_WAKE_BIT];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      transceiver_speed_select_o <= 2'h0;
      termination_select_o <= 1'b0;
      opmode_o <= 2'h0;
      cmp_en_o <= 4'h0;
      fs_rx_en_o <= 1'b1;
    end else begin
      transceiver_speed_select_o <= speed;
      termination_select_o <= func_ctrl[FC_TERM_BIT];
      opmode_o <= opmode;
      // a comparator with neither edge enabled may be switched off
      cmp_en_o <= lp_now ? (rise_en | fall_en) : 4'hF;
      fs_rx_en_o <= 1'b1;
    end
  end

  // shared counter: entry edges, then start-up time
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 16'h0000;
    end else if (state != next_state) begin
      cnt <= 16'h0000;
    end else if (cnt != 16'hFFFF) begin
      cnt <= cnt + 16'h0001;
    end
  end

  // low power interrupt, sticky until the next entry
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq <= 1'b0;
      cmp_last <= '0;
    end else begin
      cmp_last <= cmp_s;
      if (lp_now && ((rise_hit | fall_hit) != 4'h0)) begin
        irq <= 1'b1;
      end else if (state == M_LP_ENTER) begin
        irq <= 1'b0;
      end
    end
  end

  // end of transmit and receive command requests; a set beats a clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_end <= 1'b0;
      rx_req <= 1'b0;
      ls_last <= 2'h0;
    end else begin
      ls_last <= linestate;
      if (state == M_TX && nxt_o && stp_i) begin
        tx_end <= 1'b1;
      end else if (ser_done) begin
        tx_end <= 1'b0;
      end
      if (ser_done || (tx_end && fs_ls && ls_change)) begin
        rx_req <= 1'b1;
      end else if (next_state == M_RX_TA) begin
        rx_req <= 1'b0;
      end
    end
  end

  // bit rate divider
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_cnt <= 7'h00;
    end else if (ser == X_IDLE && !ser_start) begin
      bit_cnt <= 7'h00;
    end else begin
      bit_cnt <= bit_tick ? bit_cycles - 7'h01 : bit_cnt - 7'h01;
    end
  end

  // serializer: sync, stuffing, nrzi, end of packet
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ser <= X_IDLE;
      shreg <= 8'h00;
      have <= 1'b0;
      bit_idx <= 3'h0;
      ones <= 3'h0;
      eop_cnt <= 2'h0;
      level <= 1'b1;
      ser_done <= 1'b0;
    end else begin
      ser_done <= 1'b0;
      case (ser)
        X_IDLE: begin
          level <= 1'b1;
          if (ser_start) begin
            ser <= X_DATA;
            shreg <= SYNC_BYTE;
            have <= 1'b1;
            bit_idx <= 3'h0;
            ones <= 3'h0;
          end
        end
        X_DATA: begin
          if (bit_tick) begin
            if (stuff) begin
              level <= ~level;
              ones <= 3'h0;
            end else if (avail) begin
              level <= cur_bit ? level : ~level;
              ones <= cur_bit ? ones + 3'h1 : 3'h0;
              shreg <= cur_byte;
              have <= (bit_idx != 3'h7);
              bit_idx <= bit_idx + 3'h1;
            end else if (tx_end) begin
              ser <= X_SE0;
              eop_cnt <= 2'h0;
            end
          end
        end
        X_SE0: begin
          if (bit_tick) begin
            eop_cnt <= eop_cnt + 2'h1;
            if (eop_cnt == 2'(EOP_SE0_BITS - 1)) begin
              ser <= X_J;
              eop_cnt <= 2'h0;
              level <= 1'b1;
            end
          end
        end
        X_J: begin
          if (bit_tick && eop_cnt == 2'(EOP_J_BITS - 1)) begin
            ser <= X_IDLE;
            ser_done <= 1'b1;
          end
        end
        default: ser <= X_IDLE;
      endcase
    end
  end

  // line drivers; low speed J has the opposite polarity
  wire ls_pol = (speed == SPEED_LS);
  wire se0 = (ser == X_SE0);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dp_o <= 1'b0;
      dm_o <= 1'b0;
      line_oe_o <= 1'b0;
    end else begin
      dp_o <= se0 ? 1'b0 : level ^ ls_pol;
      dm_o <= se0 ? 1'b0 : ~level ^ ls_pol;
      line_oe_o <= (ser != X_IDLE) && (opmode != OPMODE_NODRIVE) && !lp_now;
    end
  end
endmodule

// *** sim/ulpi_link_model.sv ***
`timescale 1ns/1ns
module ulpi_link_model
  import ulpi_lp_pkg::*;
(
  // interface
  input wire logic clk_i,
  input wire logic dir_i,
  input wire logic nxt_i,
  output logic [7:0] data_o,
  output logic oe_o,
  output logic stp_o,
  // handshake limit ran out
  output logic hang_o
);
  logic [7:0] value;

  assign data_o = value;
  // idle is 00h whenever the device does not own the bus
  assign oe_o = !dir_i;

  initial begin
    value = 8'h00;
    stp_o = 1'b0;
    hang_o = 1'b0;
  end

  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk_i);
    value = b;
    // byte held until an edge samples nxt high
    do begin @(posedge clk_i); n++; end while (nxt_i !== 1'b1 && n < 200);
    if (n >= 200) hang_o = 1'b1;
  endtask

  task automatic tx(input logic [3:0] pid, input logic [7:0] b[$]);
    put({TXCMD_TYPE, TXCMD_SUB, pid});
    foreach (b[i]) put(b[i]);
  endtask

  task automatic end_tx();
    int n;
    n = 0;
    // stp only raised in a cycle already showing nxt high
    do begin @(negedge clk_i); n++; end while (nxt_i !== 1'b1 && n < 200);
    if (n >= 200) hang_o = 1'b1;
    stp_o = 1'b1;
    value = 8'h00;
    @(negedge clk_i);
    stp_o = 1'b0;
  endtask

  task automatic wr(input logic [5:0] addr, input logic [7:0] val);
    put({REGW_TYPE, addr});
    put(val);
    @(negedge clk_i);
    stp_o = 1'b1;
    value = 8'h00;
    @(negedge clk_i);
    stp_o = 1'b0;
  endtask

  // k = 0: hold stp until dir drops; k > 0: release early after k cycles
  task automatic wake(input int k);
    int n;
    n = 0;
    stp_o = 1'b1;
    do begin @(negedge clk_i); n++; end while (k == 0 ? (dir_i !== 1'b0 && n < 400) : n < k);
    if (k == 0 && n >= 400) hang_o = 1'b1;
    stp_o = 1'b0;
  endtask
endmodule

// *** sim/ulpi_tx_low_power_ctrl_asserts.sv ***
`timescale 1ns/1ns
module ulpi_lp_checker
  import ulpi_lp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // watched outputs
  input wire logic [7:0] data_o,
  input wire logic data_oe_o,
  input wire logic dir_o,
  input wire logic nxt_o,
  input wire logic clock_output_pin_en_o,
  input wire logic line_oe_o,
  input wire logic fs_rx_en_o,
  input wire logic low_power_o,
  input wire logic [1:0] opmode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // a receive command owns the bus for exactly two cycles
  sequence rx_turn_s;
    !dir_o ##1 dir_o [*2] ##1 !dir_o;
  endsequence

  rxcmd_frame_a: assert property (rx_turn_s |-> $past(data_oe_o) && $past(data_o[6:4]) == 3'h0)
    else $error("receive command frame malformed");
  turn_cycle_a: assert property ($rose(dir_o) |-> !data_oe_o ##1 (data_oe_o == dir_o))
    else $error("no turnaround cycle after dir rise");
  link_owns_a: assert property (!dir_o |-> !data_oe_o)
    else $error("device drives bus while dir low");
  entry_edges_a: assert property ($fell(clock_output_pin_en_o) |-> dir_o && $past(dir_o, 5))
    else $error("clock stopped too early");
  stopped_dir_a: assert property (!clock_output_pin_en_o |-> dir_o)
    else $error("clock stopped without dir high");
  wake_order_a: assert property ($fell(dir_o) |-> clock_output_pin_en_o)
    else $error("dir dropped before clock restart");
  lp_bus_a: assert property (!clock_output_pin_en_o && data_oe_o |-> data_o[7:4] == 4'h0 && !data_o[2])
    else $error("reserved low power bits not low");
  lp_power_a: assert property (low_power_o |-> fs_rx_en_o && dir_o)
    else $error("full speed receiver off in low power");
  nodrive_a: assert property (opmode_o == OPMODE_NODRIVE && $past(opmode_o) == OPMODE_NODRIVE |-> !line_oe_o)
    else $error("lines driven in non-driving mode");
  nxt_owner_a: assert property (nxt_o |-> !dir_o)
    else $error("nxt raised while device owns bus");
endmodule

// *** sim/ulpi_tx_low_power_ctrl_bench.sv ***
`timescale 1ns/1ns
module ulpi_tx_low_power_ctrl_bench;
  import ulpi_lp_pkg::*;
  logic clk_i, rstn_i, stp, lp_dp, lp_dm, link_oe, hang;
  logic dir, nxt, data_oe, clk_en, line_oe, dp_o, dm_o, low_power, fs_rx_en, term;
  logic [7:0] bus, dev_data, link_data, rx_last;
  logic [3:0] cmp_en;
  logic [1:0] speed, opmode;
  cmp_t cmp;
  int fail_count, n_checks, rx_n, se0_run, se0_len, cyc, stall_n, oe_n;
  logic [7:0] q[$];

  // released bus falls to the weak pull-downs
  wire lp_dp_w, lp_dm_w;
  assign bus = data_oe ? dev_data : (link_oe ? link_data : 8'h00);
  assign lp_dp_w = line_oe ? dp_o : lp_dp;
  assign lp_dm_w = line_oe ? dm_o : lp_dm;

  ulpi_tx_low_power_ctrl #(.START_CYCLES(20), .FAST_START_CYCLES(10), .FIFO_DEPTH(FIFO_DEPTH_DFLT))
  u_ulpi_tx_low_power_ctrl (.clk_i(clk_i), .rstn_i(rstn_i), .data_i(bus), .data_o(dev_data), .data_oe_o(data_oe),
    .stp_i(stp), .dir_o(dir), .nxt_o(nxt), .clock_output_pin_en_o(clk_en), .dp_rx_i(lp_dp_w),
    .dm_rx_i(lp_dm_w), .dp_o(dp_o), .dm_o(dm_o), .line_oe_o(line_oe), .cmp_i(cmp), .cmp_en_o(cmp_en),
    .fs_rx_en_o(fs_rx_en), .low_power_o(low_power), .transceiver_speed_select_o(speed),
    .termination_select_o(term), .opmode_o(opmode));

  ulpi_link_model u_ulpi_link_model (.clk_i(clk_i), .dir_i(dir), .nxt_i(nxt), .data_o(link_data),
    .oe_o(link_oe), .stp_o(stp), .hang_o(hang));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // sampled mid-cycle so every registered output has settled
  always @(negedge clk_i) begin
    if (data_oe && clk_en && !low_power) begin
      rx_n++;
      rx_last = dev_data;
    end
    if (line_oe && !dp_o && !dm_o) se0_run++;
    else if (se0_run != 0) begin
      se0_len = se0_run;
      se0_run = 0;
    end
    if (line_oe) oe_n++;
    // link offering a payload byte that the device does not take
    if (!dir && !nxt && !stp && link_data != 8'h00) stall_n++;
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic send_pkt(input logic [3:0] pid, input string name);
    int n;
    rx_n = 0;
    stall_n = 0;
    se0_len = 0;
    u_ulpi_link_model.tx(pid, q);
    u_ulpi_link_model.end_tx();
    n = 0;
    do begin @(negedge clk_i); n++; end while (!(se0_len != 0 && !line_oe) && n < 3000);
    chk({name, " end seen"}, 1, n < 3000);
    repeat (30) @(negedge clk_i);
    chk({name, " se0 cycles"}, EOP_SE0_BITS * FS_BIT_CYCLES, se0_len);
    chk({name, " line rxcmds"}, 1, rx_n >= 2);
    chk({name, " final rxcmd"}, 8'h0D, rx_last);
    $display("test %s done", name);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    int n;
    rstn_i = 1'b0;
    cmp = 4'h3;
    lp_dp = 1'b1;
    lp_dm = 1'b0;
    repeat (5) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (5) @(negedge clk_i);
    q = '{8'hA5, 8'hFF, 8'h01};
    send_pkt(4'h3, "fs transmit");
    q = '{8'hF0, 8'h12, 8'h34};
    send_pkt(NOPID, "token");
    q = {};
    for (int i = 1; i <= 34; i++) q.push_back(8'(i));
    send_pkt(4'h1, "long transmit");
    chk("nxt stalls", 1, stall_n > 8);
    u_ulpi_link_model.wr(FUNC_CTRL_ADDR, 8'h49);
    repeat (3) @(negedge clk_i);
    chk("func fields", {2'h1, 1'b0, OPMODE_NODRIVE, 1'b0}, {speed, term, opmode, line_oe});
    // a whole packet in the non-driving mode must leave the lines released
    q = '{8'h5A, 8'hFF};
    oe_n = 0;
    u_ulpi_link_model.tx(4'h3, q);
    u_ulpi_link_model.end_tx();
    repeat (600) @(negedge clk_i);
    chk("nodrive lines", 0, oe_n);
    u_ulpi_link_model.wr(SPEED_TUNE_ADDR, 8'h01);
    u_ulpi_link_model.wr(IRQ_FALL_ADDR, 8'h00);
    $display("test registers done");
    u_ulpi_link_model.wr(FUNC_CTRL_ADDR, 8'h09);
    n = 0;
    do begin @(negedge clk_i); n += dir; end while (clk_en !== 1'b0 && n < 100);
    chk("dir edges before stop", 1, n >= LP_ENTRY_EDGES && clk_en === 1'b0);
    repeat (3) @(negedge clk_i);
    chk("low power outputs", {1'b1, 1'b1, 4'hF}, {low_power, fs_rx_en, cmp_en});
    lp_dp = 1'b0;
    lp_dm = 1'b1;
    cmp.bus_power_valid = 1'b0;
    repeat (10) @(negedge clk_i);
    chk("lp bus masked edge", 8'h02, bus);
    cmp.id_grounded = 1'b1;
    repeat (10) @(negedge clk_i);
    chk("lp bus interrupt", 8'h0A, bus);
    lp_dp = 1'b1;
    lp_dm = 1'b0;
    $display("test low power entry done");
    u_ulpi_link_model.wake(3);
    repeat (40) @(negedge clk_i);
    chk("false resume", 2'b10, {dir, clk_en});
    u_ulpi_link_model.wake(0);
    chk("wake", 2'b01, {dir, clk_en});
    u_ulpi_link_model.wr(SPEED_TUNE_ADDR, 8'h00);
    repeat (20) @(negedge clk_i);
    chk("exit bit restored", 2'b01, {dir, clk_en});
    chk("link handshake", 0, hang);
    $display("test wake done");
    report_and_stop();
  end
endmodule

bind ulpi_tx_low_power_ctrl ulpi_lp_checker u_ulpi_lp_checker (.clk_i(clk_i), .rstn_i(rstn_i), .data_o(data_o),
  .data_oe_o(data_oe_o), .dir_o(dir_o), .nxt_o(nxt_o), .clock_output_pin_en_o(clock_output_pin_en_o),
  .line_oe_o(line_oe_o), .fs_rx_en_o(fs_rx_en_o), .low_power_o(low_power_o), .opmode_o(opmode_o));
